/* src/hms_pkg.sv */
// Constants, address map and word layouts for the host message sorter
`default_nettype none
package hms_pkg;
  // Order word layout; bit 23 holds parity on the bus, check flag after the FIFO
  typedef struct packed {
    logic       chk;
    logic       app;
    logic       maint;
    logic       prio;
    logic [3:0] mtype;
    logic [7:0] mid;
    logic [7:0] low;
  } hms_order_s;
  // Reply buffer entry
  typedef struct packed {
    logic [3:0]  code;
    logic [11:0] arg;
  } hms_reply_s;
  localparam int ORDER_W    = 24;
  localparam int AM_W       = 16;
  localparam int FIFO_DEPTH = 256;
  localparam int N_DEST     = 16;
  localparam int BUF_LEN    = 32;
  localparam int REPLY_LEN  = 16;
  // Application message types
  localparam logic [3:0] MT_PARAM  = 4'h1;
  localparam logic [3:0] MT_SWITCH = 4'h2;
  // Parameter numbers
  localparam logic [7:0] PN_MEMSIZE = 8'h00;
  localparam logic [7:0] PN_AUDIT   = 8'h01;
  localparam logic [7:0] PN_EMASK_L = 8'h02;
  localparam logic [7:0] PN_EMASK_H = 8'h03;
  localparam logic [7:0] MEMSIZE_RST = 8'h01;
  localparam logic [7:0] MEMSIZE_MAX = 8'h0c;
  // Reply codes
  localparam logic [3:0] RC_PARITY  = 4'h1;
  localparam logic [3:0] RC_COUNT   = 4'h2;
  localparam logic [3:0] RC_ACK     = 4'h3;
  localparam logic [3:0] RC_RANGE   = 4'h4;
  localparam logic [3:0] RC_OVERFL  = 4'h5;
  localparam logic [3:0] RC_LINKERR = 4'h6;
  localparam logic [3:0] RC_AUDIT   = 4'h7;
  localparam logic [3:0] RC_BUSY    = 4'h8;
  // Answer memory word addresses
  localparam logic [9:0] AM_REPLY    = 10'h000;
  localparam logic [9:0] AM_CTRL     = 10'h010;
  localparam logic [9:0] AM_FIFO_CNT = 10'h011;
  localparam logic [9:0] AM_UNLD_TBL = 10'h020;
  localparam logic [9:0] AM_LOAD_TBL = 10'h040;
  localparam logic [9:0] AM_SWITCH   = 10'h060;
  localparam logic [9:0] AM_OUTBUF   = 10'h080;
  localparam logic [9:0] AM_PARAM    = 10'h300;
  // Link error repeat period
  localparam int CLK_HZ       = 20_000_000;
  localparam int REPEAT_MS    = 250;
  localparam int REPEAT_CYC   = CLK_HZ / 1000 * REPEAT_MS;
endpackage : hms_pkg
`default_nettype wire

/* src/hms_sorter.sv */
// Host message sorter: input FIFO, word sorting, answer memory and parameter table
//
// The plain strobed port and the placing of the registers were decided locally.
`default_nettype none
module hms_sorter #(
  parameter int REPEAT_CYCLES = hms_pkg::REPEAT_CYC
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Host order bus pins
  input  wire logic [23:0]             order_word,
  input  wire logic                    order_strobe,
  // Answer memory port
  input  wire logic [9:0]              am_addr,
  input  wire logic [15:0]             am_wdata,
  input  wire logic                    am_wr,
  input  wire logic                    am_rd,
  output logic [15:0]                  am_rdata,
  // Transmit buffer drain from link side
  input  wire logic                    tx_rd,
  input  wire logic [3:0]              tx_dest,
  output logic [15:0]                  tx_data,
  output logic                         tx_avail,
  // Received link data
  input  wire logic                    rx_valid,
  input  wire logic [3:0]              rx_dest,
  input  wire logic [15:0]             rx_data,
  // Link events
  input  wire logic [15:0]             link_err,
  input  wire logic                    audit_fail,
  input  wire logic                    switch_done,
  // Orders handed on
  output logic                         ctrl_now,
  output logic                         ctrl_late_valid,
  input  wire logic                    ctrl_late_take,
  output logic                         app_order,
  output hms_pkg::hms_order_s          order_out,
  output logic [7:0]                   memsize
);
  if (REPEAT_CYCLES < 2)
  begin : g_bad_repeat
    $error("REPEAT_CYCLES too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; data is stable while the strobe is high
  logic [23:0] w_s1, w_s2;
  logic [2:0]  stb_s;
  always_ff @(posedge clk)
  begin
    w_s1  <= order_word;
    w_s2  <= w_s1;
    stb_s <= rst_n ? {stb_s[1:0], order_strobe} : 3'b000;
  end
  logic push;
  assign push = stb_s[1] & ~stb_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // Input FIFO
  logic [23:0] fifo_mem [hms_pkg::FIFO_DEPTH];
  logic [8:0]  wptr, rptr;
  logic        fifo_empty, fifo_full, pop, w_v;
  hms_pkg::hms_order_s w;
  assign fifo_empty = (wptr == rptr);
  // Full drops the new word; writing anyway would clobber the oldest unread one
  assign fifo_full  = ((wptr - rptr) == 9'h100);
  assign pop        = ~fifo_empty;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wptr <= 9'h000;
    else if (push && !fifo_full)
      wptr <= wptr + 9'h001;
  end
  // Check flag set when odd parity held
  always_ff @(posedge clk)
  begin
    if (push && !fifo_full)
      fifo_mem[wptr[7:0]] <= {^w_s2, w_s2[22:0]};
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rptr <= 9'h000;
    else if (pop)
      rptr <= rptr + 9'h001;
  end
  always_ff @(posedge clk)
  begin
    w_v <= rst_n & pop;
    w   <= fifo_mem[rptr[7:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word classification
  logic is_bad, is_head, is_data, is_maint, is_param;
  assign is_bad   = w_v & ~w.chk;
  assign is_maint = w_v & w.chk & w.maint;
  assign is_param = is_maint & w.app & (w.mtype == hms_pkg::MT_PARAM);
  assign is_head  = w_v & w.chk & ~w.maint & ({w.app, w.prio, w.mtype} != 6'h00);
  assign is_data  = w_v & w.chk & ~w.maint & ({w.app, w.prio, w.mtype} == 6'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Message tracking against the heading count
  logic       in_msg, cnt_err;
  logic [7:0] remain;
  logic [3:0] cur_dest;
  assign cnt_err = (is_data & ~in_msg) | ((is_head | is_maint | is_bad) & in_msg)
                 | (is_head & (w.low == 8'h00));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      in_msg   <= 1'b0;
      remain   <= 8'h00;
      cur_dest <= 4'h0;
    end
    else if (is_head && w.low != 8'h00)
    begin
      in_msg   <= (w.low != 8'h01);
      remain   <= w.low - 8'h01;
      cur_dest <= w.mid[3:0];
    end
    else if (is_data && in_msg)
    begin
      in_msg <= (remain != 8'h01);
      remain <= remain - 8'h01;
    end
    else if (cnt_err)
      in_msg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffers: words commit only when the count completes
  logic [15:0] tx_mem [hms_pkg::N_DEST * hms_pkg::BUF_LEN];
  logic [4:0]  tx_tent, tx_ld [hms_pkg::N_DEST], tx_ul [hms_pkg::N_DEST];
  logic [15:0] dest_unld [hms_pkg::N_DEST];
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_tent <= 5'h00;
    else if (is_head)
      tx_tent <= tx_ld[w.mid[3:0]];
    else if (is_data && in_msg)
      tx_tent <= tx_tent + 5'h01;
  end
  always_ff @(posedge clk)
  begin
    if (is_data && in_msg)
      tx_mem[{cur_dest, tx_tent}] <= {w.mid, w.low};
  end
  // Load pointer moves only on a complete message
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      for (int i = 0; i < hms_pkg::N_DEST; i++)
        tx_ld[i] <= 5'h00;
    else if (is_data && in_msg && remain == 8'h01)
      tx_ld[cur_dest] <= tx_tent + 5'h01;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      for (int i = 0; i < hms_pkg::N_DEST; i++)
      begin
        tx_ul[i]     <= 5'h00;
        dest_unld[i] <= 16'h0000;
      end
    else if (tx_rd && tx_avail)
    begin
      tx_ul[tx_dest]     <= tx_ul[tx_dest] + 5'h01;
      dest_unld[tx_dest] <= dest_unld[tx_dest] + 16'h0001;
    end
  end
  assign tx_avail = (tx_ld[tx_dest] != tx_ul[tx_dest]);
  always_ff @(posedge clk)
  begin
    tx_data <= tx_mem[{tx_dest, tx_ul[tx_dest]}];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Maintenance orders
  // Priority controller orders pulse out now, others wait in one slot
  always_ff @(posedge clk)
  begin
    ctrl_now  <= rst_n & is_maint & ~w.app & w.prio;
    app_order <= rst_n & is_maint & w.app & ~is_param;
    if (!rst_n)
      order_out <= '0;
    else if (is_maint)
      order_out <= w;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_late_valid <= 1'b0;
    else if (is_maint && !w.app && !w.prio)
      ctrl_late_valid <= 1'b1;
    else if (ctrl_late_take)
      ctrl_late_valid <= 1'b0;
  end
  logic switching, sw_busy;
  assign sw_busy = is_maint & w.app & (w.mtype == hms_pkg::MT_SWITCH) & switching;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      switching <= 1'b0;
    else if (is_maint && w.app && w.mtype == hms_pkg::MT_SWITCH)
      switching <= 1'b1;
    else if (switch_done)
      switching <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter table
  // Number is the byte index
  logic [7:0] ptab [256];
  logic [7:0] audit;
  logic [15:0] emask;
  logic        ms_bad;
  assign ms_bad = is_param & (w.mid == hms_pkg::PN_MEMSIZE)
                & ((w.low == 8'h00) | (w.low > hms_pkg::MEMSIZE_MAX));
  always_ff @(posedge clk)
  begin
    if (is_param && !ms_bad)
      ptab[w.mid] <= w.low;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      memsize <= hms_pkg::MEMSIZE_RST;
    else if (is_param && w.mid == hms_pkg::PN_MEMSIZE && !ms_bad)
      memsize <= w.low;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      audit <= 8'h00;
      emask <= 16'h0000;
    end
    else if (is_param)
    begin
      if (w.mid == hms_pkg::PN_AUDIT)
        audit <= w.low;
      if (w.mid == hms_pkg::PN_EMASK_L)
        emask[7:0] <= w.low;
      if (w.mid == hms_pkg::PN_EMASK_H)
        emask[15:8] <= w.low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link error reports; pending errors are kept so none is lost to arbitration
  logic [15:0] err_new, err_rep;
  logic [31:0] rep_tmr;
  logic [3:0]  err_idx;
  logic        err_pick;
  always_comb
  begin
    err_pick = 1'b0;
    err_idx  = 4'h0;
    for (int i = hms_pkg::N_DEST - 1; i >= 0; i--)
      if (err_new[i])
      begin
        err_pick = 1'b1;
        err_idx  = i[3:0];
      end
  end
  logic rep_tick;
  assign rep_tick = (rep_tmr == 32'(REPEAT_CYCLES - 1));
  always_ff @(posedge clk)
  begin
    if (!rst_n || rep_tick)
      rep_tmr <= 32'h0000_0000;
    else
      rep_tmr <= rep_tmr + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply buffer posting
  hms_pkg::hms_reply_s rep_mem [hms_pkg::REPLY_LEN];
  hms_pkg::hms_reply_s next_rep;
  logic [3:0] r_ld, r_ul;
  logic       want, full, lost, post, err_post;
  assign full = (r_ld + 4'h1 == r_ul);
  always_comb
  begin
    want     = 1'b1;
    err_post = 1'b0;
    next_rep = '0;
    if (is_bad)
      next_rep = {hms_pkg::RC_PARITY, w.mtype, w.mid};
    else if (cnt_err)
      next_rep = {hms_pkg::RC_COUNT, 4'h0, w.mid};
    else if (ms_bad)
      next_rep = {hms_pkg::RC_RANGE, 4'h0, w.low};
    else if (sw_busy)
      next_rep = {hms_pkg::RC_BUSY, 4'h0, w.mid};
    // Acks and audit reports gated by the audit parameter
    else if (is_param && audit != 8'h00)
      next_rep = {hms_pkg::RC_ACK, 4'h0, w.mid};
    else if (audit_fail && audit != 8'h00)
      next_rep = {hms_pkg::RC_AUDIT, 12'h000};
    else if (err_pick)
    begin
      next_rep = {hms_pkg::RC_LINKERR, 8'h00, err_idx};
      err_post = 1'b1;
    end
    else if (lost)
      next_rep = {hms_pkg::RC_OVERFL, 12'h000};
    else
      want = 1'b0;
  end
  // Post only when there is room
  assign post = want & ~full;
  always_ff @(posedge clk)
  begin
    if (post)
      rep_mem[r_ld] <= next_rep;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r_ld <= 4'h0;
    else if (post)
      r_ld <= r_ld + 4'h1;
  end
  // Set on a drop wins over the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lost <= 1'b0;
    else if (want && full && next_rep.code != hms_pkg::RC_OVERFL)
      lost <= 1'b1;
    else if (post && next_rep.code == hms_pkg::RC_OVERFL)
      lost <= 1'b0;
  end
  // New errors post once; unmasked ones repeat on the tick
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      err_new <= 16'h0000;
      err_rep <= 16'h0000;
    end
    else
    begin
      err_rep <= (err_rep | link_err) & ~emask;
      err_new <= (err_new & ~(post && err_post ? 16'(1) << err_idx : 16'h0000))
               | link_err | (rep_tick ? err_rep : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link data into circular output buffers
  logic [15:0] out_mem [hms_pkg::N_DEST * hms_pkg::BUF_LEN];
  logic [4:0]  out_ld [hms_pkg::N_DEST];
  logic [15:0] fifo_cnt;
  always_ff @(posedge clk)
  begin
    if (rx_valid)
      out_mem[{rx_dest, out_ld[rx_dest]}] <= rx_data;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      for (int i = 0; i < hms_pkg::N_DEST; i++)
        out_ld[i] <= 5'h00;
    else if (rx_valid)
      out_ld[rx_dest] <= out_ld[rx_dest] + 5'h01;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fifo_cnt <= 16'h0000;
    else if (pop)
      fifo_cnt <= fifo_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host access: only the reply unload pointer is writable
  // Control word holds both pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r_ul <= 4'h0;
    else if (am_wr && am_addr == hms_pkg::AM_CTRL)
      r_ul <= am_wdata[11:8];
  end
  // All answer words are 16 bits
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    if (am_addr < hms_pkg::AM_CTRL)
      next_rdata = rep_mem[am_addr[3:0]];
    else if (am_addr == hms_pkg::AM_CTRL)
      next_rdata = {4'h0, r_ul, 4'h0, r_ld};
    else if (am_addr == hms_pkg::AM_FIFO_CNT)
      next_rdata = fifo_cnt;
    else if (am_addr[9:4] == hms_pkg::AM_UNLD_TBL[9:4])
      next_rdata = dest_unld[am_addr[3:0]];
    else if (am_addr[9:4] == hms_pkg::AM_LOAD_TBL[9:4])
      next_rdata = {11'h000, out_ld[am_addr[3:0]]};
    else if (am_addr == hms_pkg::AM_SWITCH)
      next_rdata = {15'h0000, switching};
    else if (am_addr >= hms_pkg::AM_OUTBUF && am_addr < 10'h280)
      next_rdata = out_mem[9'(am_addr - hms_pkg::AM_OUTBUF)];
    else if (am_addr[9:7] == hms_pkg::AM_PARAM[9:7])
      next_rdata = {ptab[{am_addr[6:0], 1'b1}], ptab[{am_addr[6:0], 1'b0}]};
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      am_rdata <= 16'h0000;
    else if (am_rd)
      am_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Parity error reported next
  parity_report_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_bad && !full |=> r_ld == $past(r_ld) + 4'h1)
    else $error("parity error not posted");
  unload_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    pop |=> fifo_cnt == $past(fifo_cnt) + 16'h0001)
    else $error("fifo unload count stuck");
  full_no_post_a: assert property (@(posedge clk) disable iff (!rst_n)
    full && !(am_wr && am_addr == hms_pkg::AM_CTRL) |=> r_ld == $past(r_ld))
    else $error("posted into full reply buffer");
  memsize_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    memsize >= 8'h01 && memsize <= hms_pkg::MEMSIZE_MAX)
    else $error("memory size out of range");
  memsize_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    ms_bad |=> memsize == $past(memsize))
    else $error("bad memory size accepted");
  prio_now_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_maint && !w.app && w.prio |=> ctrl_now ##1 !ctrl_now)
    else $error("priority order not issued");
  ack_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    post && next_rep.code == hms_pkg::RC_ACK |-> audit != 8'h00)
    else $error("ack posted while audit off");
  overflow_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    post && next_rep.code == hms_pkg::RC_OVERFL |=> !lost || (want && full))
    else $error("overflow notice repeated");
  head_not_stored_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_head |=> tx_tent == tx_ld[$past(w.mid[3:0])])
    else $error("heading advanced buffer");
  switch_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_busy |=> switching)
    else $error("switch flag lost");
endmodule : hms_sorter
`default_nettype wire

/* tb/hms_host_model.sv */
// Host side model that pushes order words onto the order bus pins
`default_nettype none
module hms_host_model (
  // Clock
  input  wire logic        clk,
  // Order bus pins
  output var  logic [23:0] order_word,
  output var  logic        order_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  int sent = 0;
  initial
  begin
    order_word   = 24'h00_0000;
    order_strobe = 1'b0;
  end
  // odd parity, bad on demand
  // Strobe held four clocks high and at least six low so the synchroniser never misses an edge
  task automatic send(input logic [22:0] data, input logic bad);
    @(posedge clk);
    order_word <= {~(^data) ^ bad, data};
    @(posedge clk);
    order_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    order_strobe <= 1'b0;
    sent++;
    repeat (2) @(posedge clk);
    // Released bus shows junk, not the old word
    order_word <= ~order_word;
    repeat (2) @(posedge clk);
  endtask
endmodule // hms_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the host message sorter
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [23:0]         order_word;
  logic                order_strobe;
  logic [9:0]          am_addr = 10'h000;
  logic [15:0]         am_wdata = 16'h0000;
  logic                am_wr = 1'b0;
  logic                am_rd = 1'b0;
  logic                tx_rd = 1'b0;
  logic [3:0]          tx_dest = 4'h2;
  logic                rx_valid = 1'b0;
  logic [3:0]          rx_dest = 4'h0;
  logic [15:0]         rx_data = 16'h0000;
  logic                ctrl_late_take = 1'b0;
  logic [15:0]         am_rdata;
  logic [15:0]         tx_data;
  logic                tx_avail;
  logic                ctrl_now;
  logic                ctrl_late_valid;
  logic                app_order;
  hms_pkg::hms_order_s order_out;
  logic [7:0]          memsize;
  logic [3:0]          rp = 4'h0;
  logic [15:0]         d;
  logic [17:0]         ev = 18'h0_0000;
  logic                seen;
  int                  fail_count = 0;
  int                  checks = 0;
  always #25 clk = ~clk;
  hms_host_model host (.clk(clk), .order_word(order_word), .order_strobe(order_strobe));
  // Short repeat period keeps the run brief
  hms_sorter #(.REPEAT_CYCLES(20)) i_hms_sorter (
    .clk(clk), .rst_n(rst_n), .order_word(order_word), .order_strobe(order_strobe),
    .am_addr(am_addr), .am_wdata(am_wdata), .am_wr(am_wr), .am_rd(am_rd),
    .am_rdata(am_rdata), .tx_rd(tx_rd), .tx_dest(tx_dest), .tx_data(tx_data),
    .tx_avail(tx_avail), .rx_valid(rx_valid), .rx_dest(rx_dest), .rx_data(rx_data),
    .link_err(ev[15:0]), .audit_fail(ev[16]), .switch_done(ev[17]), .ctrl_now(ctrl_now),
    .ctrl_late_valid(ctrl_late_valid), .ctrl_late_take(ctrl_late_take),
    .app_order(app_order), .order_out(order_out), .memsize(memsize));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_w(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic am_read(input logic [9:0] a, output logic [15:0] q);
    @(posedge clk);
    am_rd   <= 1'b1;
    am_addr <= a;
    @(posedge clk);
    am_rd <= 1'b0;
    @(negedge clk);
    q = am_rdata;
  endtask
  task automatic am_write(input logic [9:0] a, input logic [15:0] w);
    @(posedge clk);
    am_wr    <= 1'b1;
    am_addr  <= a;
    am_wdata <= w;
    @(posedge clk);
    am_wr <= 1'b0;
  endtask
  // Polls the control word, then judges the newest reply entry
  task automatic wait_reply(input logic [3:0] code);
    logic [15:0] q;
    for (int n = 0; n < 60; n++)
    begin
      am_read(hms_pkg::AM_CTRL, q);
      if (q[3:0] === rp + 4'h1)
        break;
    end
    am_read(hms_pkg::AM_REPLY + {6'h00, rp}, q);
    cmp_w("reply code", {20'h0_0000, code}, {20'h0_0000, q[15:12]});
    rp = rp + 4'h1;
  endtask
  task automatic wait_hi(input int sel, output logic hit);
    logic [3:0] v;
    hit = 1'b0;
    for (int n = 0; n < 60 && !hit; n++)
    begin
      @(negedge clk);
      v   = {tx_avail, app_order, ctrl_late_valid, ctrl_now};
      hit = (v[sel] === 1'b1);
    end
  endtask
  task automatic pulse_ev(input logic [17:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 18'h0_0000;
  endtask
  task automatic pop_check(input logic [15:0] exp);
    cmp_w("tx word", {8'h00, exp}, {8'h00, tx_data});
    @(posedge clk);
    tx_rd <= 1'b1;
    @(posedge clk);
    tx_rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cmp_w("memsize", 24'h00_0001, {16'h0000, memsize});
    am_read(hms_pkg::AM_CTRL, d);
    cmp_w("reply ctrl", 24'h00_0000, {8'h00, d});
    am_read(10'h3ff, d);
    cmp_w("unmapped", 24'h00_0000, {8'h00, d});
  endtask
  task automatic t_parity;
    fork
      host.send(23'h33_abcd, 1'b1);
      wait_hi(0, seen);
    join
    cmp_w("bad word run", 24'h00_0000, {23'h00_0000, seen});
    wait_reply(hms_pkg::RC_PARITY);
  endtask
  task automatic t_params;
    host.send(23'h61_0101, 1'b0);
    repeat (30) @(posedge clk);
    am_read(hms_pkg::AM_CTRL, d);
    rp = d[3:0];
    host.send(23'h61_0005, 1'b0);
    wait_reply(hms_pkg::RC_ACK);
    cmp_w("memsize", 24'h00_0005, {16'h0000, memsize});
    host.send(23'h61_02ff, 1'b0);
    wait_reply(hms_pkg::RC_ACK);
    host.send(23'h61_0300, 1'b0);
    wait_reply(hms_pkg::RC_ACK);
    am_read(hms_pkg::AM_PARAM, d);
    cmp_w("param row 0", 24'h00_0105, {8'h00, d});
    am_read(hms_pkg::AM_PARAM + 10'h001, d);
    cmp_w("param row 1", 24'h00_00ff, {8'h00, d});
  endtask
  task automatic t_data;
    tx_dest <= 4'h2;
    fork
      begin
        host.send(23'h40_0203, 1'b0);
        host.send(23'h00_1234, 1'b0);
        host.send(23'h00_5678, 1'b0);
      end
      wait_hi(3, seen);
    join
    cmp_w("tx ready", 24'h00_0001, {23'h00_0000, seen});
    pop_check(16'h1234);
    pop_check(16'h5678);
    cmp_w("tx empty", 24'h00_0000, {23'h00_0000, tx_avail});
    am_read(hms_pkg::AM_UNLD_TBL + 10'h002, d);
    cmp_w("dest unload", 24'h00_0002, {8'h00, d});
  endtask
  task automatic t_count;
    tx_dest <= 4'h3;
    host.send(23'h40_0303, 1'b0);
    host.send(23'h00_0bad, 1'b0);
    fork
      host.send(23'h33_abcd, 1'b0);
      wait_hi(0, seen);
    join
    cmp_w("prio order", 24'hb3_abcd, order_out);
    cmp_w("prio seen", 24'h00_0001, {23'h00_0000, seen});
    wait_reply(hms_pkg::RC_COUNT);
    cmp_w("cut message", 24'h00_0000, {23'h00_0000, tx_avail});
  endtask
  task automatic t_orders;
    fork
      host.send(23'h24_0011, 1'b0);
      wait_hi(1, seen);
    join
    cmp_w("late order", 24'ha4_0011, order_out);
    cmp_w("late seen", 24'h00_0001, {23'h00_0000, seen});
    @(posedge clk);
    ctrl_late_take <= 1'b1;
    @(posedge clk);
    ctrl_late_take <= 1'b0;
    @(negedge clk);
    cmp_w("late taken", 24'h00_0000, {23'h00_0000, ctrl_late_valid});
    fork
      host.send(23'h65_0042, 1'b0);
      wait_hi(2, seen);
    join
    cmp_w("app order", 24'he5_0042, order_out);
    cmp_w("app seen", 24'h00_0001, {23'h00_0000, seen});
  endtask
  task automatic t_rx_range;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_dest  <= 4'h1;
    rx_data  <= 16'ha5a5;
    @(posedge clk);
    rx_valid <= 1'b0;
    am_read(hms_pkg::AM_LOAD_TBL + 10'h001, d);
    cmp_w("load ptr", 24'h00_0001, {8'h00, d});
    am_read(hms_pkg::AM_OUTBUF + 10'h020, d);
    cmp_w("rx word", 24'h00_a5a5, {8'h00, d});
    host.send(23'h61_000d, 1'b0);
    wait_reply(hms_pkg::RC_RANGE);
    cmp_w("memsize kept", 24'h00_0005, {16'h0000, memsize});
    am_write(hms_pkg::AM_CTRL, {4'h0, rp, 8'h00});
    am_read(hms_pkg::AM_CTRL, d);
    cmp_w("reply ctrl", {8'h00, 4'h0, rp, 4'h0, rp}, {8'h00, d});
    am_read(hms_pkg::AM_FIFO_CNT, d);
    cmp_w("fifo unload", host.sent, {8'h00, d});
  endtask
  task automatic t_events;
    host.send(23'h62_0007, 1'b0);
    am_read(hms_pkg::AM_SWITCH, d);
    cmp_w("switch flag", 24'h00_0001, {8'h00, d});
    host.send(23'h62_0007, 1'b0);
    wait_reply(hms_pkg::RC_BUSY);
    pulse_ev(18'h2_0000);
    am_read(hms_pkg::AM_SWITCH, d);
    cmp_w("switch done", 24'h00_0000, {8'h00, d});
    pulse_ev(18'h1_0000);
    wait_reply(hms_pkg::RC_AUDIT);
    host.send(23'h61_0100, 1'b0);
    wait_reply(hms_pkg::RC_ACK);
    pulse_ev(18'h1_0000);
    repeat (5) @(posedge clk);
    am_read(hms_pkg::AM_CTRL, d);
    cmp_w("audit muted", {20'h0_0000, rp}, {20'h0_0000, d[3:0]});
    // Link 1 is masked: one report and no repeats
    pulse_ev(18'h0_0002);
    wait_reply(hms_pkg::RC_LINKERR);
    repeat (60) @(posedge clk);
    am_read(hms_pkg::AM_CTRL, d);
    cmp_w("masked repeat", {20'h0_0000, rp}, {20'h0_0000, d[3:0]});
    // Link 9 repeats until the reply buffer fills and reports are dropped
    pulse_ev(18'h0_0200);
    wait_reply(hms_pkg::RC_LINKERR);
    wait_reply(hms_pkg::RC_LINKERR);
    repeat (400) @(posedge clk);
    host.send(23'h61_03ff, 1'b0);
    am_read(hms_pkg::AM_CTRL, d);
    rp = d[3:0];
    am_write(hms_pkg::AM_CTRL, {4'h0, rp, 8'h00});
    repeat (10) @(posedge clk);
    am_read(hms_pkg::AM_CTRL, d);
    cmp_w("after free", {8'h00, 4'h0, rp, 4'h0, rp + 4'h2}, {8'h00, d});
    am_read(hms_pkg::AM_REPLY + {6'h00, rp + 4'h1}, d);
    cmp_w("overflow", {20'h0_0000, hms_pkg::RC_OVERFL}, {20'h0_0000, d[15:12]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_parity();
    t_params();
    t_data();
    t_count();
    t_orders();
    t_rx_range();
    t_events();
    close_out();
  end
  // Whole sequence needs well under five thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
